/* File: sim/lin_host_model.sv */
// Programming host model: sends checksummed frames and takes responses after a short stall
`timescale 1ns/10ps
`default_nettype none

module lin_host_model (
    input wire logic ref_clk,
    input wire logic rx_ready,
    output logic rx_valid,
    output loader_cmd_pkg::rx_byte_s rx_byte,
    input wire logic resp_valid_q,
    input wire loader_cmd_pkg::resp_s resp_q,
    output logic resp_ready
);
    import loader_cmd_pkg::*;
    logic [1:0] stall_q = 2'h0;
    int resp_cnt = 0;
    resp_s resp_got = '0;

    initial begin
        rx_valid = 1'b0;
        rx_byte = '0;
    end

    // Hold off three cycles before taking each response
    assign resp_ready = resp_valid_q && (stall_q == 2'h3);

    always @(posedge ref_clk) begin
        stall_q <= !resp_valid_q ? 2'h0 : (stall_q == 2'h3 ? stall_q : stall_q + 2'h1);
        if (resp_valid_q && resp_ready) begin
            resp_cnt <= resp_cnt + 1;
            resp_got <= resp_q;
        end
    end

    task automatic send(input logic [7:0] b[$], input logic bad);
        logic [8:0] s;
        s = 9'h000;
        foreach (b[i]) begin
            s = s + {1'b0, b[i]};
            if (s[8]) s = s - 9'h0ff;
        end
        b.push_back(bad ? s[7:0] : ~s[7:0]);
        for (int i = 0; i < b.size(); i++) begin
            rx_valid = 1'b1;
            rx_byte = '{last: (i == b.size() - 1), data: b[i]};
            while (!rx_ready) begin
                @(posedge ref_clk);
                #1;
            end
            @(posedge ref_clk);
            #1;
        end
        rx_valid = 1'b0;
        rx_byte = '{last: 1'b0, data: ~b[b.size() - 1]};
    endtask : send
endmodule : lin_host_model

`default_nettype wire

/* File: sim/tb.sv */
// Testbench for the loader command checker
`timescale 1ns/10ps
`default_nettype none

module tb;
    import loader_cmd_pkg::*;
    logic ref_clk = 1'b0;
    logic resetn = 1'b0;
    logic hs_mode = 1'b0;
    prot_s prot_status = '0;
    logic exec_done = 1'b0;
    exec_s exec_result = '0;
    logic rx_valid, rx_ready, cmd_valid_q, resp_valid_q, resp_ready;
    rx_byte_s rx_byte;
    cmd_s cmd_q;
    resp_s resp_q;
    logic [1:0] baud_sel_q;
    int err_total = 0;
    int n_tests = 0;
    int cycles = 0;

    always #5 ref_clk = ~ref_clk;

    loader_cmd_checker uut (.ref_clk(ref_clk), .resetn(resetn), .hs_mode(hs_mode), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_ready(rx_ready), .prot_status(prot_status), .cmd_valid_q(cmd_valid_q),
        .cmd_q(cmd_q), .exec_done(exec_done), .exec_result(exec_result), .resp_valid_q(resp_valid_q),
        .resp_q(resp_q), .resp_ready(resp_ready), .baud_sel_q(baud_sel_q));

    lin_host_model host (.ref_clk(ref_clk), .rx_ready(rx_ready), .rx_valid(rx_valid), .rx_byte(rx_byte),
        .resp_valid_q(resp_valid_q), .resp_q(resp_q), .resp_ready(resp_ready));

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : report_and_stop

    always @(posedge ref_clk) begin
        cycles++;
        if (cycles == 60000) begin
            err_total++;
            report_and_stop();
        end
    end

    task automatic chk(input string what, input logic [23:0] seen, input logic [23:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_total++;
            $display("MISMATCH %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk

    // One frame: header with nonzero reserved and pad bytes, then play the executor and judge outputs
    task automatic xt(input logic [7:0] code, input logic [23:0] addr, input logic [7:0] num, input int pad,
                      input logic bad, input logic [8:0] res, input logic x_cmd, input logic x_resp,
                      input logic [7:0] x_err);
        logic [7:0] f[$];
        int r0;
        logic got_cmd;
        f = '{8'h06, code, addr[23:16], addr[15:8], addr[7:0], 8'h5a, num};
        repeat (pad) f.push_back(8'ha5);
        r0 = host.resp_cnt;
        got_cmd = 1'b0;
        host.send(f, bad);
        for (int i = 0; i < 300 && !got_cmd && host.resp_cnt == r0; i++) begin
            @(posedge ref_clk);
            #1;
            if (cmd_valid_q === 1'b1) got_cmd = 1'b1;
        end
        if (got_cmd) begin
            chk("cmd code", cmd_q.code, code);
            chk("cmd addr", cmd_q.addr, addr);
            chk("cmd num", cmd_q.num, num);
            chk("cmd arg", cmd_q.arg, addr[23:16]);
            repeat (3) @(posedge ref_clk);
            #1;
            exec_done = 1'b1;
            exec_result = res;
            @(posedge ref_clk);
            #1;
            exec_done = 1'b0;
        end
        repeat (12) @(posedge ref_clk);
        #1;
        chk("command issued", got_cmd, x_cmd);
        chk("response sent", host.resp_cnt != r0, x_resp);
        if (x_resp) chk("response", host.resp_got, {MSG_ACK, x_err});
    endtask : xt

    task automatic t_decode;
        logic [7:0] codes[15] = '{CMD_RAM_WRITE, CMD_RAM_EXEC, CMD_RAM_READ, CMD_NVM_WRITE, CMD_NVM_EXEC,
            CMD_NVM_READ, CMD_NVM_ERASE, CMD_NVM_PROT, CMD_PAGE_WRITE, CMD_PAGE_READ, CMD_OPT_SET,
            CMD_OPT_GET, CMD_ADDR_SET, CMD_ADDR_GET, CMD_BAUD_SET};
        logic xc, xr;
        foreach (codes[i]) begin
            xc = codes[i] != CMD_BAUD_SET;
            xr = codes[i] != CMD_RAM_EXEC && codes[i] != CMD_NVM_EXEC;
            xt(codes[i], 24'h0, 8'h01, 0, 1'b0, 9'h000, xc, xr, ERR_SUCCESS);
        end
        chk("baud", baud_sel_q, BAUD_38K4);
    endtask : t_decode

    task automatic t_data;
        xt(CMD_RAM_READ, 24'h0, 8'h10, 0, 1'b0, 9'h100, 1'b1, 1'b0, ERR_SUCCESS);
        xt(CMD_NVM_READ, 24'h0, 8'h10, 0, 1'b0, 9'h002, 1'b1, 1'b1, ERR_RANGE);
        xt(CMD_NVM_EXEC, 24'h0, 8'h00, 0, 1'b0, 9'h003, 1'b1, 1'b1, ERR_PARAMS);
        // Data and end blocks are known types and pass on without checks
        xt(BLK_DATA, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        xt(BLK_EOT, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
    endtask : t_data

    task automatic t_drop;
        xt(CMD_RAM_WRITE, 24'h0, 8'h04, 0, 1'b1, 9'h000, 1'b0, 1'b0, ERR_SUCCESS);
        xt(8'h07, 24'h0, 8'h04, 0, 1'b0, 9'h000, 1'b0, 1'b0, ERR_SUCCESS);
        xt(CMD_RAM_WRITE, 24'h0, 8'h04, 2, 1'b0, 9'h000, 1'b0, 1'b0, ERR_SUCCESS);
    endtask : t_drop

    task automatic t_limits;
        xt(CMD_RAM_WRITE, 24'h001bfc, 8'h04, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        xt(CMD_RAM_WRITE, 24'h001bfd, 8'h04, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_RANGE);
        xt(CMD_RAM_READ, 24'h001c00, 8'h80, 0, 1'b0, 9'h100, 1'b1, 1'b0, ERR_SUCCESS);
        xt(CMD_RAM_READ, 24'h001ffc, 8'h05, 0, 1'b0, 9'h100, 1'b0, 1'b1, ERR_RANGE);
        xt(CMD_NVM_WRITE, 24'h00ffff, 8'h01, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        xt(CMD_NVM_WRITE, 24'h00ffff, 8'h02, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_RANGE);
        xt(CMD_RAM_EXEC, 24'h002000, 8'h00, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_RANGE);
        xt(CMD_NVM_READ, 24'h0, 8'h00, 0, 1'b0, 9'h100, 1'b0, 1'b1, ERR_PARAMS);
    endtask : t_limits

    task automatic t_prot;
        prot_status = 3'h2;
        xt(CMD_RAM_WRITE, 24'h0, 8'h04, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_PROTECTED);
        xt(CMD_RAM_READ, 24'h0, 8'h04, 0, 1'b0, 9'h100, 1'b1, 1'b0, ERR_SUCCESS);
        prot_status = 3'h4;
        xt(CMD_NVM_ERASE, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_PROTECTED);
        xt(CMD_RAM_READ, 24'h0, 8'h00, 0, 1'b0, 9'h100, 1'b0, 1'b1, ERR_PROTECTED);
        xt(CMD_BAUD_SET, 24'h020000, 8'h00, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_PROTECTED);
        xt(CMD_OPT_SET, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_PROTECTED);
        prot_status = 3'h5;
        xt(CMD_ADDR_SET, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        prot_status = 3'h7;
        xt(CMD_NVM_PROT, 24'h0, 8'h01, 0, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        prot_status = 3'h0;
    endtask : t_prot

    task automatic t_fast;
        hs_mode = 1'b1;
        xt(CMD_RAM_WRITE, 24'h000100, 8'h04, 123, 1'b0, 9'h000, 1'b1, 1'b1, ERR_SUCCESS);
        xt(CMD_RAM_WRITE, 24'h000100, 8'h04, 124, 1'b0, 9'h000, 1'b0, 1'b0, ERR_SUCCESS);
        xt(CMD_BAUD_SET, 24'h020000, 8'h00, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_SUCCESS);
        xt(CMD_BAUD_SET, 24'h030000, 8'h00, 0, 1'b0, 9'h000, 1'b0, 1'b1, ERR_PARAMS);
        chk("baud", baud_sel_q, BAUD_230K4);
        hs_mode = 1'b0;
    endtask : t_fast

    initial begin
        repeat (4) @(posedge ref_clk);
        #1;
        resetn = 1'b1;
        for (int i = 0; i < 20 && rx_ready !== 1'b1; i++) begin
            @(posedge ref_clk);
            #1;
        end
        chk("rx ready", rx_ready, 1'b1);
        chk("baud", baud_sel_q, BAUD_RESET);
        t_decode();
        t_data();
        t_drop();
        t_limits();
        t_prot();
        t_fast();
        report_and_stop();
    end
endmodule : tb

`default_nettype wire

/* File: verilog/loader_cmd_checker.sv */
// Loader command checker: frame validation, decode, limit and protection gating, responses
// What this block does
// - Every command can return an acknowledge carrying its outcome error code.
// - Successful data-returning commands send only data; errors send the error code.
// - Execute commands answer nothing on success, only when they cannot run.
// - Frames with bad checksum, length, or unknown type are rejected.
// - Rejected frames are dropped without any response.
// - RAM codes write, execute and read are decoded.
// - Memory write, execute, read, erase, protection, page write and read decoded.
// - Option set/get, node address set/get and baud set are decoded.
// - Unused filler bytes are ignored whatever their value.
// - High-speed variant tolerates padding up to 128 data bytes, keeps real data.
// - With padding, the byte after the last pad is the checksum.
// - RAM reads cover all RAM; writes into loader stack area fail.
// - RAM and memory write, read and execute check their address range and error when exceeded; erase and page accesses are not checked.
// - A RAM or memory read or write with zero byte count is rejected with an error.
// - RAM write, memory write, erase blocked by any read or write protection.
// - Execute, read, page read, gets and baud set blocked by read protection.
// - Page write, option set, address set blocked on read protection without code write protection.
// - Protection set or clear skips all protection checks.
// - Permission is evaluated first; a protection violation answers with an error.
// - Frames end with a checksum computed as on the standard link.
// - Session baud rates 38.4, 115.2 and 230.4 kBd are supported.
`timescale 1ns/10ps
`default_nettype none

module byte_fifo #(
    parameter int WIDTH = 9,
    parameter int DEPTH = 16
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic in_valid,
    input wire logic [WIDTH-1:0] in_data,
    output logic in_ready,
    output logic out_valid,
    output logic [WIDTH-1:0] out_data,
    input wire logic out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wp_q, wp_d, rp_q, rp_d;
    logic [AW:0] cnt_q, cnt_d;
    logic ready_q, ready_d, push, pop;

    assign in_ready = ready_q;
    assign out_valid = (cnt_q != '0);
    assign out_data = mem[rp_q];

    always_comb begin
        push = in_valid & ready_q;
        pop = out_valid & out_ready;
        wp_d = push ? AW'(wp_q + 1'b1) : wp_q;
        rp_d = pop ? AW'(rp_q + 1'b1) : rp_q;
        cnt_d = cnt_q;
        if (push && !pop) begin
            cnt_d = (AW+1)'(cnt_q + 1'b1);
        end else if (pop && !push) begin
            cnt_d = (AW+1)'(cnt_q - 1'b1);
        end
        ready_d = (cnt_d != (AW+1)'(DEPTH));
    end

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_q] <= in_data;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_q <= '0;
            rp_q <= '0;
            cnt_q <= '0;
            ready_q <= 1'b0;
        end else begin
            wp_q <= wp_d;
            rp_q <= rp_d;
            cnt_q <= cnt_d;
            ready_q <= ready_d;
        end
    end
endmodule : byte_fifo

module loader_cmd_checker #(
    parameter logic [24:0] RAM_SIZE = 25'h0002000,
    parameter logic [24:0] RAM_RSVD_BASE = 25'h0001c00,
    parameter logic [24:0] NVM_SIZE = 25'h0010000
) (
    input wire logic ref_clk,
    input wire logic resetn,
    input wire logic hs_mode,
    input wire logic rx_valid,
    input wire loader_cmd_pkg::rx_byte_s rx_byte,
    output logic rx_ready,
    input wire loader_cmd_pkg::prot_s prot_status,
    output logic cmd_valid_q,
    output loader_cmd_pkg::cmd_s cmd_q,
    input wire logic exec_done,
    input wire loader_cmd_pkg::exec_s exec_result,
    output logic resp_valid_q,
    output loader_cmd_pkg::resp_s resp_q,
    input wire logic resp_ready,
    output logic [1:0] baud_sel_q
);
    import loader_cmd_pkg::*;

    logic rst_meta_q, rst_n;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    function automatic logic [7:0] min_len(input logic [7:0] c);
        case (c)
            CMD_RAM_WRITE, CMD_RAM_READ, CMD_NVM_WRITE, CMD_NVM_READ: min_len = MIN_LEN_MEM;
            CMD_RAM_EXEC, CMD_NVM_EXEC: min_len = MIN_LEN_EXEC;
            default: min_len = MIN_LEN_OTHER;
        endcase
    endfunction : min_len

    function automatic logic known(input logic [7:0] c);
        case (c)
            CMD_RAM_WRITE, CMD_RAM_EXEC, CMD_RAM_READ: known = 1'b1;
            CMD_NVM_WRITE, CMD_NVM_EXEC, CMD_NVM_READ, CMD_NVM_ERASE, CMD_NVM_PROT,
            CMD_PAGE_WRITE, CMD_PAGE_READ: known = 1'b1;
            CMD_OPT_SET, CMD_OPT_GET, CMD_ADDR_SET, CMD_ADDR_GET, CMD_BAUD_SET: known = 1'b1;
            BLK_DATA, BLK_EOT: known = 1'b1;
            default: known = 1'b0;
        endcase
    endfunction : known

    function automatic logic prot_block(input logic [7:0] c, input prot_s p);
        case (c)
            CMD_RAM_WRITE, CMD_NVM_WRITE, CMD_NVM_ERASE: prot_block = p.rd_any | p.wr_any;
            CMD_RAM_EXEC, CMD_NVM_EXEC, CMD_NVM_READ, CMD_RAM_READ, CMD_PAGE_READ,
            CMD_OPT_GET, CMD_ADDR_GET, CMD_BAUD_SET: prot_block = p.rd_any;
            CMD_PAGE_WRITE, CMD_OPT_SET, CMD_ADDR_SET: prot_block = p.rd_any & ~p.wr_code;
            CMD_NVM_PROT: prot_block = 1'b0;
            default: prot_block = 1'b0;
        endcase
    endfunction : prot_block

    function automatic logic [7:0] sum_carry(input logic [7:0] s, input logic [7:0] b);
        logic [8:0] t;
        t = {1'b0, s} + {1'b0, b};
        sum_carry = t[7:0] + {7'h00, t[8]};
    endfunction : sum_carry

    logic fifo_valid, fifo_ready;
    rx_byte_s fifo_byte;
    byte_fifo #(.WIDTH($bits(rx_byte_s)), .DEPTH(FIFO_DEPTH)) u_fifo (
        .clk(ref_clk),
        .rst_n(rst_n),
        .in_valid(rx_valid),
        .in_data(rx_byte),
        .in_ready(rx_ready),
        .out_valid(fifo_valid),
        .out_data(fifo_byte),
        .out_ready(fifo_ready)
    );

    parse_state_e st_q, st_d;
    logic [7:0] len_q, len_d, idx_q, idx_d, sum_q, sum_d, chk_q, chk_d;
    cmd_s cmd_d, fld_q, fld_d;
    logic cmd_valid_d, resp_valid_d;
    resp_s resp_d;
    logic [1:0] baud_d;
    logic take, is_mem, is_exec, len_ok, frame_ok, blocked;
    logic [24:0] end_addr, limit;
    logic [7:0] err;

    assign fifo_ready = (st_q == ST_LEN) || (st_q == ST_BODY);

    always_comb begin
        take = fifo_valid & fifo_ready;
        is_mem = (fld_q.code == CMD_RAM_WRITE) || (fld_q.code == CMD_RAM_READ) ||
                 (fld_q.code == CMD_NVM_WRITE) || (fld_q.code == CMD_NVM_READ);
        is_exec = (fld_q.code == CMD_RAM_EXEC) || (fld_q.code == CMD_NVM_EXEC);
        // Padding on the fast variant: checksum is whatever byte closes the frame
        len_ok = hs_mode ? (idx_q >= 8'(len_q + 8'h01)) && (idx_q <= 8'(HS_MAX_DATA + 8'h02))
                         : (idx_q == 8'(len_q + 8'h01));
        frame_ok = (~sum_q == chk_q) && len_ok && (len_q != 8'h00) && (len_q <= MAX_LEN) &&
                   known(fld_q.code) && (len_q >= min_len(fld_q.code));
        blocked = prot_block(fld_q.code, prot_status);
        end_addr = {1'b0, fld_q.addr} + (is_mem ? {17'h00000, fld_q.num} : 25'h0000001);
        limit = (fld_q.code == CMD_RAM_WRITE) ? RAM_RSVD_BASE :
                ((fld_q.code == CMD_RAM_READ) || (fld_q.code == CMD_RAM_EXEC)) ? RAM_SIZE : NVM_SIZE;
        err = ERR_SUCCESS;
        if (blocked) begin
            err = ERR_PROTECTED;
        end else if (is_mem && fld_q.num == 8'h00) begin
            err = ERR_PARAMS;
        end else if ((is_mem || is_exec) && end_addr > limit) begin
            err = ERR_RANGE;
        end else if (fld_q.code == CMD_BAUD_SET && fld_q.arg > BAUD_230K4) begin
            err = ERR_PARAMS;
        end
    end

    always_comb begin
        st_d = st_q;
        len_d = len_q;
        idx_d = idx_q;
        sum_d = sum_q;
        chk_d = chk_q;
        fld_d = fld_q;
        cmd_d = cmd_q;
        cmd_valid_d = 1'b0;
        resp_valid_d = resp_valid_q;
        resp_d = resp_q;
        baud_d = baud_sel_q;
        case (st_q)
            ST_LEN: begin
                if (take && !fifo_byte.last) begin
                    len_d = fifo_byte.data;
                    sum_d = fifo_byte.data;
                    idx_d = POS_TYPE;
                    fld_d = '0;
                    st_d = ST_BODY;
                end
            end
            ST_BODY: begin
                if (take) begin
                    if (fifo_byte.last) begin
                        chk_d = fifo_byte.data;
                        st_d = ST_EVAL;
                    end else begin
                        sum_d = sum_carry(sum_q, fifo_byte.data);
                        idx_d = (idx_q == 8'hff) ? idx_q : 8'(idx_q + 8'h01);
                        // Only real fields are kept; filler and padding fall through
                        if (idx_q <= len_q) begin
                            if (idx_q == POS_TYPE) fld_d.code = fifo_byte.data;
                            if (idx_q >= POS_ADDR0 && idx_q <= POS_ADDR2) fld_d.addr = {fld_q.addr[15:0], fifo_byte.data};
                            if (idx_q == POS_ADDR0) fld_d.arg = fifo_byte.data;
                            if (idx_q == POS_NUM) fld_d.num = fifo_byte.data;
                        end
                    end
                end
            end
            ST_EVAL: begin
                if (!frame_ok) begin
                    st_d = ST_LEN;
                end else if (err != ERR_SUCCESS) begin
                    resp_valid_d = 1'b1;
                    resp_d = '{msg_type: MSG_ACK, err: err};
                    st_d = ST_RESP;
                end else if (fld_q.code == CMD_BAUD_SET) begin
                    baud_d = fld_q.arg[1:0];
                    resp_valid_d = 1'b1;
                    resp_d = '{msg_type: MSG_ACK, err: ERR_SUCCESS};
                    st_d = ST_RESP;
                end else begin
                    cmd_valid_d = 1'b1;
                    cmd_d = fld_q;
                    st_d = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (exec_done) begin
                    if (exec_result.err != ERR_SUCCESS) begin
                        resp_valid_d = 1'b1;
                        resp_d = '{msg_type: MSG_ACK, err: exec_result.err};
                        st_d = ST_RESP;
                    end else if (exec_result.has_data || is_exec) begin
                        st_d = ST_LEN;
                    end else begin
                        resp_valid_d = 1'b1;
                        resp_d = '{msg_type: MSG_ACK, err: ERR_SUCCESS};
                        st_d = ST_RESP;
                    end
                end
            end
            ST_RESP: begin
                if (resp_ready) begin
                    resp_valid_d = 1'b0;
                    st_d = ST_LEN;
                end
            end
            default: st_d = ST_LEN;
        endcase
    end

    always_ff @(posedge ref_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_q <= ST_LEN;
            len_q <= 8'h00;
            idx_q <= 8'h00;
            sum_q <= 8'h00;
            chk_q <= 8'h00;
            fld_q <= '0;
            cmd_q <= '0;
            cmd_valid_q <= 1'b0;
            resp_valid_q <= 1'b0;
            resp_q <= '0;
            baud_sel_q <= BAUD_RESET;
        end else begin
            st_q <= st_d;
            len_q <= len_d;
            idx_q <= idx_d;
            sum_q <= sum_d;
            chk_q <= chk_d;
            fld_q <= fld_d;
            cmd_q <= cmd_d;
            cmd_valid_q <= cmd_valid_d;
            resp_valid_q <= resp_valid_d;
            resp_q <= resp_d;
            baud_sel_q <= baud_d;
        end
    end

    property p_drop_silent;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && !frame_ok) |=> (st_q == ST_LEN && !resp_valid_q && !cmd_valid_q);
    endproperty
    a_drop_silent: assert property (p_drop_silent) else $error("invalid frame not dropped silently");
    property p_prot_err;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && frame_ok && blocked) |=> (resp_valid_q && resp_q.err == ERR_PROTECTED && !cmd_valid_q);
    endproperty
    a_prot_err: assert property (p_prot_err) else $error("protected command not refused");
    property p_zero_count;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && frame_ok && !blocked && is_mem && fld_q.num == 8'h00) |=> (resp_q.err == ERR_PARAMS);
    endproperty
    a_zero_count: assert property (p_zero_count) else $error("zero count accepted");
    property p_data_no_ack;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_WAIT && exec_done && exec_result.err == ERR_SUCCESS && exec_result.has_data)
            |=> !resp_valid_q [*2];
    endproperty
    a_data_no_ack: assert property (p_data_no_ack) else $error("ack sent with data");
    property p_exec_silent;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_WAIT && exec_done && exec_result.err == ERR_SUCCESS && is_exec) |=> (st_q == ST_LEN && !resp_valid_q);
    endproperty
    a_exec_silent: assert property (p_exec_silent) else $error("execute answered on success");
    property p_exec_err;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_WAIT && exec_done && exec_result.err != ERR_SUCCESS)
            |=> (resp_valid_q && resp_q.err == $past(exec_result.err) && resp_q.msg_type == MSG_ACK);
    endproperty
    a_exec_err: assert property (p_exec_err) else $error("error not acknowledged");
    property p_resp_hold;
        @(posedge ref_clk) disable iff (!rst_n)
        (resp_valid_q && !resp_ready) |=> (resp_valid_q && $stable(resp_q));
    endproperty
    a_resp_hold: assert property (p_resp_hold) else $error("response dropped before taken");
    property p_prot_bypass;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && frame_ok && fld_q.code == CMD_NVM_PROT) |=> (cmd_valid_q && cmd_q.code == CMD_NVM_PROT);
    endproperty
    a_prot_bypass: assert property (p_prot_bypass) else $error("protection command blocked");
    property p_ram_rsvd;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && frame_ok && !blocked && fld_q.code == CMD_RAM_WRITE && fld_q.num != 8'h00 &&
         end_addr > RAM_RSVD_BASE) |=> (resp_valid_q && resp_q.err == ERR_RANGE);
    endproperty
    a_ram_rsvd: assert property (p_ram_rsvd) else $error("write into loader area accepted");
    property p_baud;
        @(posedge ref_clk) disable iff (!rst_n)
        (st_q == ST_EVAL && frame_ok && err == ERR_SUCCESS && fld_q.code == CMD_BAUD_SET)
            |=> (baud_sel_q == $past(fld_q.arg[1:0]));
    endproperty
    a_baud: assert property (p_baud) else $error("baud selection not taken");
    c_cmd_issued: cover property (@(posedge ref_clk) disable iff (!rst_n) cmd_valid_q);
    c_err_resp: cover property (@(posedge ref_clk) disable iff (!rst_n) resp_valid_q && resp_q.err != ERR_SUCCESS);
    c_drop: cover property (@(posedge ref_clk) disable iff (!rst_n) st_q == ST_EVAL && !frame_ok);
    c_padded: cover property (@(posedge ref_clk) disable iff (!rst_n) st_q == ST_EVAL && frame_ok && idx_q > len_q + 8'h01);
endmodule : loader_cmd_checker

`default_nettype wire

/* File: verilog/loader_cmd_pkg.sv */
// Constants and carriers shared by the loader command checker
package loader_cmd_pkg;
    // Command and block codes
    localparam logic [7:0] CMD_RAM_WRITE = 8'h02;
    localparam logic [7:0] CMD_RAM_EXEC = 8'h83;
    localparam logic [7:0] CMD_RAM_READ = 8'h84;
    localparam logic [7:0] CMD_NVM_WRITE = 8'h05;
    localparam logic [7:0] CMD_NVM_EXEC = 8'h86;
    localparam logic [7:0] CMD_NVM_READ = 8'h87;
    localparam logic [7:0] CMD_NVM_ERASE = 8'h88;
    localparam logic [7:0] CMD_NVM_PROT = 8'h89;
    localparam logic [7:0] CMD_PAGE_WRITE = 8'h0d;
    localparam logic [7:0] CMD_PAGE_READ = 8'h8e;
    localparam logic [7:0] CMD_OPT_SET = 8'h8f;
    localparam logic [7:0] CMD_OPT_GET = 8'h90;
    localparam logic [7:0] CMD_ADDR_SET = 8'h91;
    localparam logic [7:0] CMD_ADDR_GET = 8'h92;
    localparam logic [7:0] CMD_BAUD_SET = 8'h93;
    localparam logic [7:0] BLK_DATA = 8'h00;
    localparam logic [7:0] BLK_EOT = 8'h80;
    localparam logic [7:0] MSG_ACK = 8'h81;
    // Error codes carried in the acknowledge
    localparam logic [7:0] ERR_SUCCESS = 8'h00;
    localparam logic [7:0] ERR_PROTECTED = 8'h01;
    localparam logic [7:0] ERR_RANGE = 8'h02;
    localparam logic [7:0] ERR_PARAMS = 8'h03;
    // Frame layout: byte positions counted from the length byte
    localparam logic [7:0] POS_TYPE = 8'h01;
    localparam logic [7:0] POS_ADDR0 = 8'h02;
    localparam logic [7:0] POS_ADDR2 = 8'h04;
    localparam logic [7:0] POS_NUM = 8'h06;
    localparam logic [7:0] MIN_LEN_MEM = 8'h06;
    localparam logic [7:0] MIN_LEN_EXEC = 8'h04;
    localparam logic [7:0] MIN_LEN_OTHER = 8'h01;
    localparam logic [7:0] MAX_LEN = 8'h81;
    localparam logic [7:0] HS_MAX_DATA = 8'h80;
    // Session baud selections: 38.4, 115.2, 230.4 kBd
    localparam logic [1:0] BAUD_38K4 = 2'h0;
    localparam logic [1:0] BAUD_115K2 = 2'h1;
    localparam logic [1:0] BAUD_230K4 = 2'h2;
    localparam logic [1:0] BAUD_RESET = BAUD_115K2;
    localparam int FIFO_DEPTH = 16;

    typedef struct packed {logic last; logic [7:0] data;} rx_byte_s;
    typedef struct packed {logic [7:0] code; logic [23:0] addr; logic [7:0] num; logic [7:0] arg;} cmd_s;
    typedef struct packed {logic [7:0] msg_type; logic [7:0] err;} resp_s;
    typedef struct packed {logic has_data; logic [7:0] err;} exec_s;
    typedef struct packed {logic rd_any; logic wr_any; logic wr_code;} prot_s;
    typedef enum logic [2:0] {ST_LEN, ST_BODY, ST_EVAL, ST_WAIT, ST_RESP} parse_state_e;
endpackage : loader_cmd_pkg
